//--- verilog/lxb_top.sv
// Top of the upper-lane crossbar: map registers, status and interrupt.
// Assumes a master that keeps strobes one cycle long and never overlapping.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lxb_regs.svh"

module lxb_top
    import lxb_pkg::*;
(
    input  wire logic                                i_clk,
    input  wire logic                                i_reset_n,
    input  wire logic                                i_clk_en,
    input  wire logic [`LXB_ADDR_W-1:0]              i_addr,
    input  wire logic [`LXB_DATA_W-1:0]              i_wdata,
    input  wire logic                                i_wr,
    input  wire logic                                i_rd,
    output logic      [`LXB_DATA_W-1:0]              o_rdata,
    input  wire logic [`LXB_PHYS_N*`LXB_LANE_W-1:0]  i_phys_data,
    input  wire logic [`LXB_PHYS_N-1:0]              i_phys_valid,
    input  wire logic [`LXB_PHYS_N-1:0]              i_fifo_full,
    input  wire logic [`LXB_PHYS_N-1:0]              i_fifo_empty,
    output logic      [`LXB_LOG_N*`LXB_LANE_W-1:0]   o_log_data,
    output logic      [`LXB_LOG_N-1:0]               o_log_valid,
    output logic                                     o_irq
);
    // Selector registers; reserved bits 7:6 are simply not stored.
    lxb_sel_type  sel4_r;
    lxb_sel_type  sel5_r;
    lxb_sel_type  sel6_r;
    lxb_sel_type  sel7_r;
    lxb_sel_type  sel4_nxt;
    lxb_sel_type  sel5_nxt;
    lxb_sel_type  sel6_nxt;
    lxb_sel_type  sel7_nxt;
    lxb_byte_type mask_r;
    lxb_byte_type mask_nxt;
    lxb_byte_type rdata_r;
    lxb_byte_type rdata_nxt;

    logic [`LXB_PHYS_N-1:0] full_r;
    logic [`LXB_PHYS_N-1:0] empty_r;
    logic [`LXB_PHYS_N-1:0] evt_r;

    // Bus decode.
    logic         hit_map45;
    logic         hit_map67;
    logic         hit_full;
    logic         hit_empty;
    logic         hit_irq;
    logic         hit_mask;
    logic         wr_en;
    logic         rd_en;
    logic         wr_map45;
    logic         wr_map67;
    logic         wr_mask;
    logic         irq_clr;
    lxb_byte_type map45_view;
    lxb_byte_type map67_view;
    lxb_byte_type rd_value;

    assign wr_en     = i_clk_en & i_wr;
    assign rd_en     = i_clk_en & i_rd;
    assign hit_map45 = (i_addr == `LXB_ADDR_MAP45);
    assign hit_map67 = (i_addr == `LXB_ADDR_MAP67);
    assign hit_full  = (i_addr == `LXB_ADDR_FULL);
    assign hit_empty = (i_addr == `LXB_ADDR_EMPTY);
    assign hit_irq   = (i_addr == `LXB_ADDR_IRQ);
    assign hit_mask  = (i_addr == `LXB_ADDR_MASK);
    assign wr_map45  = wr_en & hit_map45;
    assign wr_map67  = wr_en & hit_map67;
    assign wr_mask   = wr_en & hit_mask;
    // Reading the event register clears it.
    assign irq_clr   = rd_en & hit_irq;

    assign sel5_nxt = wr_map45 ? i_wdata[`LXB_HI_MSB:`LXB_HI_LSB] : sel5_r;
    assign sel4_nxt = wr_map45 ? i_wdata[`LXB_LO_MSB:`LXB_LO_LSB] : sel4_r;
    assign sel7_nxt = wr_map67 ? i_wdata[`LXB_HI_MSB:`LXB_HI_LSB] : sel7_r;
    assign sel6_nxt = wr_map67 ? i_wdata[`LXB_LO_MSB:`LXB_LO_LSB] : sel6_r;
    assign mask_nxt = wr_mask  ? i_wdata : mask_r;

    // Reserved bits are tied low in the read view.
    assign map45_view = {2'h0, sel5_r, sel4_r};
    assign map67_view = {2'h0, sel7_r, sel6_r};

    // Unmapped addresses read as zero.
    assign rd_value = hit_map45 ? map45_view :
                      hit_map67 ? map67_view :
                      hit_full  ? full_r     :
                      hit_empty ? empty_r    :
                      hit_irq   ? evt_r      :
                      hit_mask  ? mask_r     : `LXB_RST_BYTE;

    // Read data stand from the strobe's edge until the next enabled edge.
    assign rdata_nxt = i_rd ? rd_value : `LXB_RST_BYTE;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel4_r <= `LXB_RST_SEL4;
            sel5_r <= `LXB_RST_SEL5;
            sel6_r <= `LXB_RST_SEL6;
            sel7_r <= `LXB_RST_SEL7;
        end else if (i_clk_en) begin
            sel4_r <= sel4_nxt;
            sel5_r <= sel5_nxt;
            sel6_r <= sel6_nxt;
            sel7_r <= sel7_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_r  <= `LXB_RST_BYTE;
            rdata_r <= `LXB_RST_BYTE;
        end else if (i_clk_en) begin
            mask_r  <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
    // Level interrupt, high while an unmasked event bit stands.
    assign o_irq   = |(evt_r & mask_r);

    lxb_lane_status u_status (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_full    (i_fifo_full),
        .i_empty   (i_fifo_empty),
        .i_evt_clr (irq_clr),
        .o_full    (full_r),
        .o_empty   (empty_r),
        .o_evt     (evt_r)
    );

    // Logical lanes 4..7 in output order 0..3.
    lxb_sel_type sel_of [`LXB_LOG_N];

    assign sel_of[0] = sel4_r;
    assign sel_of[1] = sel5_r;
    assign sel_of[2] = sel6_r;
    assign sel_of[3] = sel7_r;

    for (genvar g = 0; g < `LXB_LOG_N; g++) begin : g_lane
        lxb_lane_mux u_mux (
            .i_clk        (i_clk),
            .i_reset_n    (i_reset_n),
            .i_clk_en     (i_clk_en),
            .i_sel        (sel_of[g]),
            .i_phys_data  (i_phys_data),
            .i_phys_valid (i_phys_valid),
            .o_data       (o_log_data[g*`LXB_LANE_W +: `LXB_LANE_W]),
            .o_valid      (o_log_valid[g])
        );
    end

    // Checking helpers; nothing in the datapath reads them.
    lxb_word_type log_w [`LXB_LOG_N];
    lxb_word_type phys_w [`LXB_PHYS_N];
    logic         wr45_seen_r;
    logic         wr67_seen_r;
    logic         en_seen_r;
    // The write data bus is delayed one cycle, whether or not a write is on it, so a check can see which code a write brought in.
    lxb_byte_type wdata_q_r;
    lxb_word_type pick_w [`LXB_LOG_N];
    logic         pickv_w [`LXB_LOG_N];
    lxb_word_type pick_hi_w;
    lxb_word_type pick_lo_w;
    logic         valid_hi_w;
    lxb_byte_type rise_w;

    for (genvar l = 0; l < `LXB_LOG_N; l++) begin : g_logw
        assign log_w[l] = o_log_data[l*`LXB_LANE_W +: `LXB_LANE_W];
    end
    for (genvar p = 0; p < `LXB_PHYS_N; p++) begin : g_physw
        assign phys_w[p] = i_phys_data[p*`LXB_LANE_W +: `LXB_LANE_W];
    end

    // Words each lane should carry next, so that no check needs a nested sampled value.
    for (genvar k = 0; k < `LXB_LOG_N; k++) begin : g_pick
        assign pick_w[k]  = lxb_pick(i_phys_data, sel_of[k]);
        assign pickv_w[k] = i_phys_valid[sel_of[k]];
    end

    assign pick_hi_w  = lxb_pick(i_phys_data, wdata_q_r[`LXB_HI_MSB:`LXB_HI_LSB]);
    assign pick_lo_w  = lxb_pick(i_phys_data, wdata_q_r[`LXB_LO_MSB:`LXB_LO_LSB]);
    assign valid_hi_w = i_phys_valid[wdata_q_r[`LXB_HI_MSB:`LXB_HI_LSB]];
    assign rise_w     = i_fifo_full & ~full_r;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr45_seen_r <= 1'b0;
            wr67_seen_r <= 1'b0;
            en_seen_r   <= 1'b0;
            wdata_q_r   <= `LXB_RST_BYTE;
        end else begin
            wr45_seen_r <= wr45_seen_r | wr_map45;
            wr67_seen_r <= wr67_seen_r | wr_map67;
            en_seen_r   <= en_seen_r | i_clk_en;
            wdata_q_r   <= i_wdata;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_wr45;
        i_clk_en && i_wr && i_addr == `LXB_ADDR_MAP45;
    endsequence

    sequence s_wr67;
        i_clk_en && i_wr && i_addr == `LXB_ADDR_MAP67;
    endsequence

    sequence s_rd(logic [`LXB_ADDR_W-1:0] a);
        i_clk_en && i_rd && i_addr == a;
    endsequence

    // Reset is sampled too, so no check starts at the edge that releases it.
    sequence s_en_step;
        i_clk_en && i_reset_n;
    endsequence

    a_lane5_route: assert property (
        s_en_step |=> log_w[1] == $past(pick_w[1]))
        else $error("logical lane 5 does not carry its selected lane");

    a_lane5_write: assert property (
        s_wr45 ##1 s_en_step |=>
            log_w[1] == $past(pick_hi_w))
        else $error("logical lane 5 ignores a new selector");

    a_map45_reset: assert property (
        !wr45_seen_r |-> sel4_r == `LXB_RST_SEL4 && sel5_r == `LXB_RST_SEL5)
        else $error("first map register lost its reset selectors");

    a_lane4_route: assert property (
        s_en_step |=> log_w[0] == $past(pick_w[0])
            && o_log_valid[0] == $past(pickv_w[0]))
        else $error("logical lane 4 does not carry its selected lane");

    a_lane7_write: assert property (
        s_wr67 ##1 s_en_step |=>
            o_log_valid[3] == $past(valid_hi_w))
        else $error("logical lane 7 ignores a new selector");

    a_map67_reset: assert property (
        !wr67_seen_r |-> sel6_r == `LXB_RST_SEL6 && sel7_r == `LXB_RST_SEL7)
        else $error("second map register lost its reset selectors");

    a_lane6_route: assert property (
        s_en_step |=> log_w[2] == $past(pick_w[2]))
        else $error("logical lane 6 does not carry its selected lane");

    a_code_first: assert property (
        i_clk_en && sel4_r == `LXB_SEL_FIRST |=> log_w[0] == $past(phys_w[0]))
        else $error("code zero does not pick physical lane 0");

    a_code_last: assert property (
        i_clk_en && sel6_r == `LXB_SEL_LAST |=> log_w[2] == $past(phys_w[7]))
        else $error("code seven does not pick physical lane 7");

    a_full_read: assert property (
        s_rd(`LXB_ADDR_FULL) ##1 s_en_step |-> o_rdata == $past(i_fifo_full, 2))
        else $error("full status read does not show the lane flags");

    a_status_reset: assert property (
        !en_seen_r |-> full_r == `LXB_RST_BYTE && empty_r == `LXB_RST_BYTE)
        else $error("status registers not zero out of reset");

    a_empty_read: assert property (
        s_rd(`LXB_ADDR_EMPTY) |=> o_rdata == $past(i_fifo_empty, 2))
        else $error("empty status read does not show the lane flags");

    a_reserved_zero: assert property (
        s_rd(`LXB_ADDR_MAP45) or s_rd(`LXB_ADDR_MAP67) |=>
            o_rdata[`LXB_RSVD_MSB:`LXB_RSVD_LSB] == 2'h0)
        else $error("reserved map bits do not read as zero");

    a_irq_clear: assert property (
        s_rd(`LXB_ADDR_IRQ) ##0 !(|(i_fifo_full & ~full_r)) |=> evt_r == '0)
        else $error("event register not cleared by its read");

    a_lane7_route: assert property (
        s_en_step |=> log_w[3] == $past(pick_w[3]))
        else $error("logical lane 7 does not carry its selected lane");

    a_lane5_valid: assert property (
        s_en_step |=> o_log_valid[1] == $past(pickv_w[1]))
        else $error("logical lane 5 valid does not follow its lane");

    a_lane6_valid: assert property (
        s_en_step |=> o_log_valid[2] == $past(pickv_w[2]))
        else $error("logical lane 6 valid does not follow its lane");

    a_lane7_valid: assert property (
        s_en_step |=> o_log_valid[3] == $past(pickv_w[3]))
        else $error("logical lane 7 valid does not follow its lane");

    // A new code must steer the lane from the very next enabled edge.
    a_lane4_write: assert property (
        s_wr45 ##1 s_en_step |=> log_w[0] == $past(pick_lo_w))
        else $error("logical lane 4 ignores a new selector");

    a_lane6_write: assert property (
        s_wr67 ##1 s_en_step |=> log_w[2] == $past(pick_lo_w))
        else $error("logical lane 6 ignores a new selector");

    a_lane5_first: assert property (
        s_en_step ##0 sel5_r == `LXB_SEL_FIRST |=> log_w[1] == $past(phys_w[0]))
        else $error("code zero does not pick physical lane 0 on lane 5");

    a_lane7_last: assert property (
        s_en_step ##0 sel7_r == `LXB_SEL_LAST |=> log_w[3] == $past(phys_w[7]))
        else $error("code seven does not pick physical lane 7 on lane 7");

    a_full_track: assert property (
        s_en_step |=> full_r == $past(i_fifo_full))
        else $error("full status does not follow the lane flags");

    a_empty_track: assert property (
        s_en_step |=> empty_r == $past(i_fifo_empty))
        else $error("empty status does not follow the lane flags");

    // The set wins, so a flag that rises in the clearing cycle survives the read.
    a_evt_set: assert property (
        s_en_step ##0 rise_w != '0 |=> (evt_r & $past(rise_w)) == $past(rise_w))
        else $error("a rising full flag did not set its event bit");

    a_irq_masked: assert property (
        mask_r == `LXB_RST_BYTE |-> !o_irq)
        else $error("interrupt raised with every event masked");

    a_rdata_idle: assert property (
        s_en_step ##0 !i_rd |=> o_rdata == `LXB_RST_BYTE)
        else $error("read data stand outside the cycle after a read");

    a_en_freeze: assert property (
        !i_clk_en |=> $stable(o_log_data) && $stable(o_log_valid) && $stable(o_rdata))
        else $error("outputs moved while the clock enable was low");

    a_sel_frozen: assert property (
        !i_clk_en |=> $stable(sel4_r) && $stable(sel5_r) && $stable(sel6_r) && $stable(sel7_r))
        else $error("a selector moved while the clock enable was low");

endmodule // lxb_top

`default_nettype wire

//--- verilog/lxb_regs.svh
// Register map and constants of the upper-lane crossbar block.
// Assumes one 25 MHz clock and a plain 8-bit register port.
// Functional notes
// - Logical lane 5 carries the physical lane named by bits 5:3 of the first map register, reset 5.
// - Logical lane 4 carries the physical lane named by bits 2:0 of the first map register, reset 4.
// - Logical lane 7 carries the physical lane named by bits 5:3 of the second map register, reset 7.
// - Logical lane 6 carries the physical lane named by bits 2:0 of the second map register, reset 6.
// - A selector code is a plain binary physical lane index, 000 for lane 0 up to 111 for lane 7.
// - An 8-bit read-only register shows in bit x the full flag of lane buffer x, reset zero.
// - An 8-bit read-only register shows in bit x the empty flag of lane buffer x, reset zero.
`ifndef LXB_REGS_SVH
`define LXB_REGS_SVH

`define LXB_ADDR_W      10
`define LXB_DATA_W      8
`define LXB_LANE_W      16
`define LXB_PHYS_N      8
`define LXB_LOG_N       4

`define LXB_ADDR_MAP45  10'h30a
`define LXB_ADDR_MAP67  10'h30b
`define LXB_ADDR_FULL   10'h30c
`define LXB_ADDR_EMPTY  10'h30d
`define LXB_ADDR_IRQ    10'h30e
`define LXB_ADDR_MASK   10'h30f

`define LXB_HI_MSB      5
`define LXB_HI_LSB      3
`define LXB_LO_MSB      2
`define LXB_LO_LSB      0
`define LXB_RSVD_MSB    7
`define LXB_RSVD_LSB    6

`define LXB_RST_SEL4    3'h4
`define LXB_RST_SEL5    3'h5
`define LXB_RST_SEL6    3'h6
`define LXB_RST_SEL7    3'h7
`define LXB_SEL_FIRST   3'h0
`define LXB_SEL_LAST    3'h7
`define LXB_RST_BYTE    8'h00

`endif

//--- verilog/lxb_pkg.sv
// Types and the lane pick function of the upper-lane crossbar block.
// Assumes the constants header is on the include path.
`include "lxb_regs.svh"

package lxb_pkg;
    typedef logic [2:0]               lxb_sel_type;
    typedef logic [`LXB_LANE_W-1:0]   lxb_word_type;
    typedef logic [`LXB_DATA_W-1:0]   lxb_byte_type;

    // The code is taken as a binary lane index, so every code is legal.
    function automatic lxb_word_type lxb_pick(
        input logic [`LXB_PHYS_N*`LXB_LANE_W-1:0] data,
        input lxb_sel_type                        sel
    );
        lxb_pick = data[sel*`LXB_LANE_W +: `LXB_LANE_W];
    endfunction
endpackage

//--- verilog/lxb_lane_mux.sv
// One logical lane output of the crossbar, registered.
// Assumes physical lane words and valids arrive on the block clock.
`timescale 1ns/1ps
`default_nettype none
`include "lxb_regs.svh"

module lxb_lane_mux
    import lxb_pkg::*;
(
    input  wire logic                                i_clk,
    input  wire logic                                i_reset_n,
    input  wire logic                                i_clk_en,
    input  wire lxb_sel_type                         i_sel,
    input  wire logic [`LXB_PHYS_N*`LXB_LANE_W-1:0]  i_phys_data,
    input  wire logic [`LXB_PHYS_N-1:0]              i_phys_valid,
    output logic      [`LXB_LANE_W-1:0]              o_data,
    output logic                                     o_valid
);
    lxb_word_type data_nxt;
    logic         valid_nxt;

    assign data_nxt  = lxb_pick(i_phys_data, i_sel);
    assign valid_nxt = i_phys_valid[i_sel];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_data  <= '0;
            o_valid <= 1'b0;
        end else if (i_clk_en) begin
            o_data  <= data_nxt;
            o_valid <= valid_nxt;
        end
    end
endmodule // lxb_lane_mux

`default_nettype wire

//--- verilog/lxb_lane_status.sv
// Registered lane buffer flags and sticky full events.
// Assumes the buffer flags come from logic on the block clock.
`timescale 1ns/1ps
`default_nettype none
`include "lxb_regs.svh"

module lxb_lane_status
    import lxb_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_clk_en,
    input  wire logic [`LXB_PHYS_N-1:0] i_full,
    input  wire logic [`LXB_PHYS_N-1:0] i_empty,
    input  wire logic                   i_evt_clr,
    output logic      [`LXB_PHYS_N-1:0] o_full,
    output logic      [`LXB_PHYS_N-1:0] o_empty,
    output logic      [`LXB_PHYS_N-1:0] o_evt
);
    logic [`LXB_PHYS_N-1:0] full_rise;
    logic [`LXB_PHYS_N-1:0] evt_nxt;

    assign full_rise = i_full & ~o_full;
    // A new event in the clearing cycle survives the clear.
    assign evt_nxt   = (i_evt_clr ? '0 : o_evt) | full_rise;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_full  <= '0;
            o_empty <= '0;
            o_evt   <= '0;
        end else if (i_clk_en) begin
            o_full  <= i_full;
            o_empty <= i_empty;
            o_evt   <= evt_nxt;
        end
    end
endmodule // lxb_lane_status

`default_nettype wire

//--- test/lxb_lane_source.sv
// Model of the multi-lane serial transmitter that feeds the eight physical lanes.
// Assumes the block clock and reset of the crossbar; words change right after each edge.
`timescale 1ns/1ps
`default_nettype none
`include "lxb_regs.svh"

module lxb_lane_source
    import lxb_pkg::*;
(
    input  wire logic                                i_clk,
    input  wire logic                                i_reset_n,
    input  wire logic                                i_slow,
    output logic      [`LXB_PHYS_N*`LXB_LANE_W-1:0]  o_phys_data,
    output logic      [`LXB_PHYS_N-1:0]              o_phys_valid
);
    logic [11:0] count_r;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_r <= 12'h000;
        end else begin
            count_r <= count_r + 12'h001;
        end
    end

    // Each word carries its lane number and changes every cycle, so a stale or wrong pick shows.
    // In slow mode valid gaps alternate between neighbouring lanes.
    always_comb begin
        for (int p = 0; p < `LXB_PHYS_N; p++) begin
            o_phys_data[p*`LXB_LANE_W +: `LXB_LANE_W] = {p[3:0], count_r ^ {p[3:0], 8'h00}};
            o_phys_valid[p] = !i_slow || (count_r[0] ^ p[0]);
        end
    end
endmodule // lxb_lane_source

`default_nettype wire

//--- test/tb_lxb_top.sv
// Self-checking testbench of the upper-lane crossbar, register port and lane outputs.
// Assumes the transmitter model drives the physical lanes; clock 25 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "lxb_regs.svh"

module tb_lxb_top
    import lxb_pkg::*;
;
    logic                               i_clk;
    logic                               i_reset_n;
    logic                               i_clk_en;
    logic [`LXB_ADDR_W-1:0]             i_addr;
    logic [`LXB_DATA_W-1:0]             i_wdata;
    logic                               i_wr;
    logic                               i_rd;
    logic [`LXB_DATA_W-1:0]             o_rdata;
    logic [`LXB_PHYS_N*`LXB_LANE_W-1:0] i_phys_data;
    logic [`LXB_PHYS_N-1:0]             i_phys_valid;
    logic [`LXB_PHYS_N-1:0]             i_fifo_full;
    logic [`LXB_PHYS_N-1:0]             i_fifo_empty;
    logic [`LXB_LOG_N*`LXB_LANE_W-1:0]  o_log_data;
    logic [`LXB_LOG_N-1:0]              o_log_valid;
    logic                               o_irq;
    logic                               slow;
    int                                 n_mismatch;
    int                                 n_checks;

    lxb_top dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_phys_data(i_phys_data), .i_phys_valid(i_phys_valid), .i_fifo_full(i_fifo_full),
        .i_fifo_empty(i_fifo_empty), .o_log_data(o_log_data), .o_log_valid(o_log_valid),
        .o_irq(o_irq));

    lxb_lane_source src_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow(slow),
        .o_phys_data(i_phys_data), .o_phys_valid(i_phys_valid));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic check(input lxb_word_type got, input lxb_word_type exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [`LXB_ADDR_W-1:0] a, input lxb_byte_type d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand for one cycle only, so they are sampled in the middle of that cycle.
    task automatic rd(input logic [`LXB_ADDR_W-1:0] a, input lxb_byte_type exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check({8'h00, o_rdata}, {8'h00, exp});
    endtask

    task automatic chk_lane(input int g, input lxb_sel_type sel);
        lxb_word_type exp_w;
        logic         exp_v;
        @(negedge i_clk);
        exp_w = i_phys_data[sel*`LXB_LANE_W +: `LXB_LANE_W];
        exp_v = i_phys_valid[sel];
        @(negedge i_clk);
        check(o_log_data[g*`LXB_LANE_W +: `LXB_LANE_W], exp_w);
        check({15'h0000, o_log_valid[g]}, {15'h0000, exp_v});
    endtask

    task automatic do_reset();
        i_reset_n <= 1'b0;
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
    endtask

    task automatic reset_view();
        rd(`LXB_ADDR_MAP45, {2'h0, `LXB_RST_SEL5, `LXB_RST_SEL4});
        rd(`LXB_ADDR_MAP67, {2'h0, `LXB_RST_SEL7, `LXB_RST_SEL6});
        for (int g = 0; g < `LXB_LOG_N; g++) begin
            chk_lane(g, 3'(g + 4));
        end
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {i_reset_n, i_wr, i_rd, slow} = 4'h0;
        {i_clk_en, i_addr, i_wdata} = {1'b1, 10'h000, 8'h00};
        {i_fifo_full, i_fifo_empty} = 16'h0000;
        n_mismatch = 0;
        n_checks = 0;
        do_reset();
        reset_view();
        rd(`LXB_ADDR_FULL, `LXB_RST_BYTE);
        rd(`LXB_ADDR_EMPTY, `LXB_RST_BYTE);
        $display("test reset_values done");

        // Reserved bits are written as ones to show they never stick.
        for (int c = 0; c < 8; c++) begin
            @(posedge i_clk);
            slow <= (c % 2) == 1;
            wr(`LXB_ADDR_MAP45, {2'h3, 3'(7 - c), 3'(c)});
            wr(`LXB_ADDR_MAP67, {2'h3, 3'(c), 3'(7 - c)});
            rd(`LXB_ADDR_MAP45, {2'h0, 3'(7 - c), 3'(c)});
            rd(`LXB_ADDR_MAP67, {2'h0, 3'(c), 3'(7 - c)});
            chk_lane(0, 3'(c));
            chk_lane(1, 3'(7 - c));
            chk_lane(2, 3'(7 - c));
            chk_lane(3, 3'(c));
        end
        $display("test all_codes done");

        for (int x = 0; x < 8; x++) begin
            @(posedge i_clk);
            i_fifo_full <= 8'h01 << x;
            i_fifo_empty <= ~(8'h01 << x);
            rd(`LXB_ADDR_FULL, 8'h01 << x);
            rd(`LXB_ADDR_EMPTY, ~(8'h01 << x));
            wr(`LXB_ADDR_FULL, 8'haa);
            rd(`LXB_ADDR_FULL, 8'h01 << x);
        end
        $display("test status_flags done");

        // Every full flag rose once above, so all events are pending but masked.
        @(negedge i_clk);
        check({15'h0000, o_irq}, 16'h0000);
        wr(`LXB_ADDR_MASK, 8'h01);
        @(negedge i_clk);
        check({15'h0000, o_irq}, 16'h0001);
        rd(`LXB_ADDR_MASK, 8'h01);
        rd(`LXB_ADDR_IRQ, 8'hff);
        check({15'h0000, o_irq}, 16'h0000);
        rd(`LXB_ADDR_IRQ, 8'h00);
        @(posedge i_clk);
        i_fifo_full <= 8'h01;
        repeat (2) @(negedge i_clk);
        check({15'h0000, o_irq}, 16'h0001);
        wr(`LXB_ADDR_MASK, 8'h00);
        @(negedge i_clk);
        check({15'h0000, o_irq}, 16'h0000);
        rd(`LXB_ADDR_IRQ, 8'h01);
        rd(10'h300, 8'h00);
        $display("test interrupt done");

        // A strobe with the enable low must leave the map untouched.
        @(posedge i_clk);
        i_clk_en <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= `LXB_ADDR_MAP45;
        i_wdata <= 8'h00;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_clk_en <= 1'b1;
        rd(`LXB_ADDR_MAP45, 8'h07);
        $display("test clock_enable done");

        @(posedge i_clk);
        do_reset();
        reset_view();
        $display("test second_reset done");
        end_of_test();
    end
endmodule // tb_lxb_top

`default_nettype wire
